// ---- rtl/nvmc_array.sv ----
`timescale 1ns/1ns
`default_nettype none
module nvmc_array
  import nvmc_pkg::*;
#(
  parameter int DEPTH       = 256,
  parameter int WRITE_TICKS = NVMC_WRITE_TICKS,
  parameter int TICK_DIV    = NVMC_TICK_DIV
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         wr_start_i,
  input  wire logic         rd_start_i,
  input  wire nvmc_cmd_type cmd_i,
  input  wire logic         permit_i,
  output logic              wr_done_o,
  output logic              rd_done_o,
  output logic [7:0]        rd_data_o
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            tick_cnt;
    logic [15:0]           wr_cnt;
    logic                  wr_busy;
    nvmc_cmd_type          cmd;
    logic                  wr_done;
    logic                  rd_done;
    logic [7:0]            rd_data;
  } nvmc_arr_type;

  nvmc_arr_type st_reg;
  nvmc_arr_type st_next;

  // ----------------------------------------------------------------
  // write timer and storage
  // ----------------------------------------------------------------
  // the timer tick free-runs independent of any request, so the number
  // of core cycles a write takes varies with the tick phase at start
  always_comb begin
    st_next         = st_reg;
    st_next.wr_done = 1'b0;
    st_next.rd_done = 1'b0;
    st_next.tick_cnt = (st_reg.tick_cnt == 8'(TICK_DIV - 1)) ? 8'h00 : st_reg.tick_cnt + 8'h01;
    if (wr_start_i && !st_reg.wr_busy) begin
      st_next.wr_busy = 1'b1;
      st_next.cmd     = cmd_i;
      st_next.wr_cnt  = 16'h0000;
    end else if (st_reg.wr_busy && st_reg.tick_cnt == 8'h00) begin
      if (st_reg.wr_cnt == 16'(WRITE_TICKS - 1)) begin
        st_next.wr_busy = 1'b0;
        st_next.wr_done = 1'b1;
        if (permit_i) begin
          st_next.mem[st_reg.cmd.addr[$clog2(DEPTH)-1:0]] = st_reg.cmd.data;
        end
      end else begin
        st_next.wr_cnt = st_reg.wr_cnt + 16'h0001;
      end
    end
    if (rd_start_i && !st_reg.wr_busy) begin
      st_next.rd_done = 1'b1;
      st_next.rd_data = st_reg.mem[cmd_i.addr[$clog2(DEPTH)-1:0]];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg.tick_cnt <= 8'h00;
      st_reg.wr_cnt   <= 16'h0000;
      st_reg.wr_busy  <= 1'b0;
      st_reg.wr_done  <= 1'b0;
      st_reg.rd_done  <= 1'b0;
      st_reg.rd_data  <= 8'h00;
      st_reg.cmd      <= '0;
      st_reg.mem      <= st_next.mem;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wr_done_o = st_reg.wr_done;
  assign rd_done_o = st_reg.rd_done;
  assign rd_data_o = st_reg.rd_data;

endmodule : nvmc_array
`default_nettype wire

// ---- rtl/nvmc_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module nvmc_ctrl
  import nvmc_pkg::*;
#(
  parameter int ADDR_WIDTH  = NVMC_ADDR_WIDTH,
  parameter int WRITE_TICKS = NVMC_WRITE_TICKS,
  parameter int TICK_DIV    = NVMC_TICK_DIV
) (
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       gie_i,
  input  wire logic       stack_full_i,
  input  wire logic       irq_ack_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            irq_req_o
);

  localparam logic [7:0] ADDR_MASK = 8'((1 << ADDR_WIDTH) - 1);

  nvmc_ctl_type st_reg;
  nvmc_ctl_type st_next;
  nvmc_cmd_type cmd;
  logic         wr_done;
  logic         rd_done;
  logic [7:0]   rd_data;
  logic         ctrl_hit;

  // ----------------------------------------------------------------
  // array and write timer
  // ----------------------------------------------------------------
  assign cmd = '{addr: st_reg.addr, data: st_reg.data, commit_ok: st_reg.store_permit};

  nvmc_array #(
    .DEPTH       (1 << ADDR_WIDTH),
    .WRITE_TICKS (WRITE_TICKS),
    .TICK_DIV    (TICK_DIV)
  ) u_array (
    .mclk_i     (mclk_i),
    .srst_i     (srst_i),
    .wr_start_i (st_reg.wr_start),
    .rd_start_i (st_reg.rd_start),
    .cmd_i      (cmd),
    .permit_i   (st_reg.store_permit),
    .wr_done_o  (wr_done),
    .rd_done_o  (rd_done),
    .rd_data_o  (rd_data)
  );

  // control register only reachable through the indirect port in bank 1
  assign ctrl_hit = (st_reg.bank_select == NVMC_CTRL_BANK) &&
                    (st_reg.indirect_pointer == NVMC_CTRL_IND_OFS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.wr_start = 1'b0;
    st_next.rd_start = 1'b0;

    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        NVMC_ADDR_OFS: st_next.addr = sfr_wdata_i & ADDR_MASK;
        NVMC_DATA_OFS: st_next.data = sfr_wdata_i;
        NVMC_BANK_OFS: st_next.bank_select = sfr_wdata_i;
        NVMC_PTR_OFS:  st_next.indirect_pointer = sfr_wdata_i;
        NVMC_INTC_OFS: begin
          st_next.irq_enable = sfr_wdata_i[NVMC_IRQ_ENABLE_BIT];
          st_next.mf_enable  = sfr_wdata_i[NVMC_MF_ENABLE_BIT];
          st_next.irq_flag   = sfr_wdata_i[NVMC_IRQ_FLAG_BIT];
          st_next.mf_flag    = sfr_wdata_i[NVMC_MF_FLAG_BIT];
        end
        NVMC_IND_OFS: begin
          if (ctrl_hit) begin
            st_next.store_permit = sfr_wdata_i[NVMC_STORE_PERMIT_BIT];
            st_next.fetch_permit = sfr_wdata_i[NVMC_FETCH_PERMIT_BIT];
            // a trigger only rises on a permit already held; a busy one
            // cannot be cleared by software
            if (!st_reg.store_trigger && st_reg.store_permit &&
                sfr_wdata_i[NVMC_STORE_TRIGGER_BIT]) begin
              st_next.store_trigger = 1'b1;
              st_next.wr_start      = 1'b1;
            end else if (!st_reg.store_trigger && !st_reg.fetch_trigger &&
                         st_reg.fetch_permit &&
                         sfr_wdata_i[NVMC_FETCH_TRIGGER_BIT]) begin
              st_next.fetch_trigger = 1'b1;
              st_next.rd_start      = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    if (rd_done) begin
      st_next.fetch_trigger = 1'b0;
      st_next.data          = rd_data;
    end

    // completion sets after any software write, so the set wins
    if (wr_done) begin
      st_next.store_trigger = 1'b0;
      st_next.irq_flag      = 1'b1;
      st_next.mf_flag       = 1'b1;
    end else if (irq_ack_i && st_reg.vec_req) begin
      st_next.mf_flag = 1'b0;
    end

    st_next.vec_req = gie_i && st_next.irq_enable && st_next.mf_enable &&
                      st_next.mf_flag && !stack_full_i && !irq_ack_i;

    unique case (sfr_addr_i)
      NVMC_ADDR_OFS: st_next.rdata = st_next.addr & ADDR_MASK;
      NVMC_DATA_OFS: st_next.rdata = st_next.data;
      NVMC_BANK_OFS: st_next.rdata = st_next.bank_select;
      NVMC_PTR_OFS:  st_next.rdata = st_next.indirect_pointer;
      NVMC_INTC_OFS: st_next.rdata = {4'h0, st_next.mf_flag, st_next.irq_flag,
                                      st_next.mf_enable, st_next.irq_enable};
      NVMC_IND_OFS:  st_next.rdata = ctrl_hit ?
                                     {4'h0, st_next.store_permit, st_next.store_trigger,
                                      st_next.fetch_permit, st_next.fetch_trigger} :
                                     8'h00;
      default:       st_next.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg <= st_next;
      {st_reg.store_permit, st_reg.store_trigger,
       st_reg.fetch_permit, st_reg.fetch_trigger} <= NVMC_CTRL_RESET;
      st_reg.bank_select      <= NVMC_BANK_RESET;
      st_reg.indirect_pointer <= 8'h00;
      st_reg.irq_enable       <= 1'b0;
      st_reg.mf_enable        <= 1'b0;
      st_reg.irq_flag         <= 1'b0;
      st_reg.mf_flag          <= 1'b0;
      st_reg.rdata            <= 8'h00;
      st_reg.vec_req          <= 1'b0;
      st_reg.wr_start         <= 1'b0;
      st_reg.rd_start         <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata_o = st_reg.rdata;
  assign irq_req_o   = st_reg.vec_req;

endmodule : nvmc_ctrl
`default_nettype wire

// ---- rtl/nvmc_pkg.sv ----
// Contract
// - address register width 6/7/8, upper zero
// - control bits 3..0, clear at power-on
// - no array write without store permit
// - store trigger needs permit already set
// - store trigger held until byte written
// - fetch trigger needs fetch permit set
// - fetch trigger clears, data register loaded
// - data register held until next operation
// - write duration from separate internal timer
// - write end sets irq and multi-function flags
// - vector request needs all enables, stack room
// - service clears only multi-function flag
// - power-on clears permit and bank select
package nvmc_pkg;

  // ----------------------------------------------------------------
  // special-function register map
  // ----------------------------------------------------------------
  localparam logic [7:0] NVMC_ADDR_OFS     = 8'h1e;
  localparam logic [7:0] NVMC_DATA_OFS     = 8'h1f;
  localparam logic [7:0] NVMC_BANK_OFS     = 8'h04;
  localparam logic [7:0] NVMC_PTR_OFS      = 8'h03;
  localparam logic [7:0] NVMC_IND_OFS      = 8'h02;
  localparam logic [7:0] NVMC_INTC_OFS     = 8'h0e;
  localparam logic [7:0] NVMC_CTRL_IND_OFS = 8'h40;
  localparam logic [7:0] NVMC_CTRL_BANK    = 8'h01;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NVMC_STORE_PERMIT_BIT  = 3;
  localparam int NVMC_STORE_TRIGGER_BIT = 2;
  localparam int NVMC_FETCH_PERMIT_BIT  = 1;
  localparam int NVMC_FETCH_TRIGGER_BIT = 0;
  localparam int NVMC_IRQ_ENABLE_BIT    = 0;
  localparam int NVMC_MF_ENABLE_BIT     = 1;
  localparam int NVMC_IRQ_FLAG_BIT      = 2;
  localparam int NVMC_MF_FLAG_BIT       = 3;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  NVMC_CTRL_RESET    = 4'h0;
  localparam logic [7:0]  NVMC_BANK_RESET    = 8'h00;
  localparam int          NVMC_ADDR_WIDTH    = 8;
  localparam int          NVMC_WRITE_TICKS   = 32;
  localparam int          NVMC_TICK_DIV      = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       store_permit;
    logic       store_trigger;
    logic       fetch_permit;
    logic       fetch_trigger;
    logic [7:0] bank_select;
    logic [7:0] indirect_pointer;
    logic       irq_enable;
    logic       mf_enable;
    logic       irq_flag;
    logic       mf_flag;
    logic [7:0] rdata;
    logic       vec_req;
    logic       wr_start;
    logic       rd_start;
  } nvmc_ctl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       commit_ok;
  } nvmc_cmd_type;

endpackage : nvmc_pkg

// ---- tb/nvmc_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module nvmc_core_model
  import nvmc_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic [7:0] sfr_rdata_i,
  output var logic        sfr_wr_o,
  output var logic  [7:0] sfr_addr_o,
  output var logic  [7:0] sfr_wdata_o,
  output var logic        look_o,
  output var logic        hung_o
);
  initial begin
    sfr_wr_o    = 1'b0;
    sfr_addr_o  = 8'h55;
    sfr_wdata_o = 8'h00;
    look_o      = 1'b0;
    hung_o      = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sfr_wr_o    <= 1'b1;
    sfr_addr_o  <= a;
    sfr_wdata_o <= d;
    look_o      <= 1'b0;
  endtask : wr
  // look_o flags the cycle in which the read answer stands
  task automatic rd(input logic [7:0] a, input logic chk);
    @(posedge mclk_i);
    sfr_wr_o   <= 1'b0;
    sfr_addr_o <= a;
    look_o     <= 1'b0;
    @(posedge mclk_i);
    look_o <= chk;
    // look_o is a one-cycle pulse, so an idle gap after a read never pops twice
    @(posedge mclk_i);
    look_o <= 1'b0;
  endtask : rd
  task automatic idle();
    rd(8'h55, 1'b0);
  endtask : idle
  // bounded: a stuck trigger raises hung_o instead of hanging
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      rd(NVMC_IND_OFS, 1'b0);
      #1;
      if (sfr_rdata_i[b] === 1'b0) break;
    end
    if (n == 400) hung_o = 1'b1;
  endtask : poll
  task automatic sel();
    wr(NVMC_BANK_OFS, NVMC_CTRL_BANK);
    wr(NVMC_PTR_OFS, NVMC_CTRL_IND_OFS);
  endtask : sel
  task automatic store(input logic [7:0] a, input logic [7:0] d);
    wr(NVMC_IND_OFS, 8'h08);
    wr(NVMC_ADDR_OFS, a);
    wr(NVMC_DATA_OFS, d);
    wr(NVMC_IND_OFS, 8'h0c);
  endtask : store
  task automatic store_end();
    poll(NVMC_STORE_TRIGGER_BIT);
    wr(NVMC_IND_OFS, 8'h00);
  endtask : store_end
  task automatic fetch(input logic [7:0] a);
    wr(NVMC_IND_OFS, 8'h02);
    wr(NVMC_ADDR_OFS, a);
    wr(NVMC_IND_OFS, 8'h03);
    poll(NVMC_FETCH_TRIGGER_BIT);
  endtask : fetch
endmodule : nvmc_core_model
`default_nettype wire

// ---- tb/nvmc_ctrl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module nvmc_ctrl_props
  import nvmc_pkg::*;
#(
  parameter int ADDR_WIDTH  = 8,
  parameter int WRITE_TICKS = 32,
  parameter int TICK_DIV    = 5
) (
  input wire logic       mclk_i,
  input wire logic       srst_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       gie_i,
  input wire logic       stack_full_i,
  input wire logic       irq_ack_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       irq_req_o
);
  logic [7:0] bank_reg;
  logic [7:0] ptr_reg;
  wire logic  sel    = (bank_reg == NVMC_CTRL_BANK) && (ptr_reg == NVMC_CTRL_IND_OFS);
  wire logic  rd_ind = !sfr_wr_i && (sfr_addr_i == NVMC_IND_OFS);

  // shadow of the bank gate, so indirect reads can be judged
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bank_reg <= 8'h00;
      ptr_reg  <= 8'h00;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == NVMC_BANK_OFS) bank_reg <= sfr_wdata_i;
      if (sfr_addr_i == NVMC_PTR_OFS) ptr_reg <= sfr_wdata_i;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_reset_quiet: assert property ($fell(srst_i) |-> sfr_rdata_o == 8'h00 && !irq_req_o)
    else $error("outputs not quiet after reset");
  a_ctrl_upper: assert property (rd_ind |=> sfr_rdata_o[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_addr_width: assert property (sfr_addr_i == NVMC_ADDR_OFS |=> (sfr_rdata_o >> ADDR_WIDTH) == 8'h00)
    else $error("address bits above width not zero");
  a_ind_gate: assert property (rd_ind && !sel |=> sfr_rdata_o == 8'h00)
    else $error("control reachable without bank select");
  a_irq_block: assert property (!gie_i || stack_full_i || irq_ack_i |=> !irq_req_o)
    else $error("vector request while blocked");
  a_irq_cause: assert property ($rose(irq_req_o) |-> $past(gie_i) && !$past(stack_full_i))
    else $error("vector request without enables");
  a_ack_clear: assert property (irq_ack_i && irq_req_o |=> !irq_req_o [*2])
    else $error("request flag not cleared by service");
  a_fetch_done: assert property (sfr_wr_i && sfr_addr_i == NVMC_IND_OFS && sfr_wdata_i == 8'h03
    && sel ##1 rd_ind [*2] |=> sfr_rdata_o[0] == 1'b0)
    else $error("fetch trigger not cleared in time");
endmodule : nvmc_ctrl_props

bind nvmc_ctrl nvmc_ctrl_props #(.ADDR_WIDTH(ADDR_WIDTH), .WRITE_TICKS(WRITE_TICKS),
  .TICK_DIV(TICK_DIV)) i_props (.mclk_i(mclk_i), .srst_i(srst_i), .sfr_wr_i(sfr_wr_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .gie_i(gie_i),
  .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i), .sfr_rdata_o(sfr_rdata_o),
  .irq_req_o(irq_req_o));
`default_nettype wire

// ---- tb/tb_data_eeprom_access_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_data_eeprom_access_ctrl;
  import nvmc_pkg::*;
  logic       mclk_i       = 1'b0;
  logic       srst_i       = 1'b1;
  logic       gie_i        = 1'b0;
  logic       stack_full_i = 1'b0;
  logic       irq_ack_i    = 1'b0;
  wire logic  sfr_wr_i;
  wire logic  [7:0] sfr_addr_i;
  wire logic  [7:0] sfr_wdata_i;
  wire logic  [7:0] sfr_rdata_o;
  wire logic  irq_req_o;
  wire logic  look;
  wire logic  hung;
  logic [7:0] exp_q[$];
  logic [7:0] a;
  logic [7:0] d;
  int         num_errors = 0;
  int         tests_run  = 0;

  always #4 mclk_i = ~mclk_i;

  nvmc_ctrl #(.ADDR_WIDTH(6), .WRITE_TICKS(4), .TICK_DIV(2)) i_dut (.mclk_i(mclk_i),
    .srst_i(srst_i), .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .gie_i(gie_i), .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
    .sfr_rdata_o(sfr_rdata_o), .irq_req_o(irq_req_o));
  nvmc_core_model i_core (.mclk_i(mclk_i), .sfr_rdata_i(sfr_rdata_o), .sfr_wr_o(sfr_wr_i),
    .sfr_addr_o(sfr_addr_i), .sfr_wdata_o(sfr_wdata_i), .look_o(look), .hung_o(hung));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic exp_rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    i_core.rd(ad, 1'b1);
  endtask : exp_rd

  always @(posedge mclk_i) if (look === 1'b1) check(sfr_rdata_o, exp_q.pop_front());
  always @(posedge mclk_i) if (hung === 1'b1) begin
    num_errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h3255));
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    exp_rd(NVMC_BANK_OFS, 8'h00);
    exp_rd(NVMC_IND_OFS, 8'h00);
    i_core.wr(NVMC_ADDR_OFS, 8'hff);
    exp_rd(NVMC_ADDR_OFS, 8'h3f);
    i_core.sel();
    exp_rd(NVMC_IND_OFS, 8'h00);
    i_core.wr(NVMC_IND_OFS, 8'h04);
    i_core.wr(NVMC_IND_OFS, 8'h01);
    exp_rd(NVMC_IND_OFS, 8'h00);
    i_core.wr(NVMC_IND_OFS, 8'hfa);
    exp_rd(NVMC_IND_OFS, 8'h0a);
    i_core.wr(NVMC_INTC_OFS, 8'h03);
    // vector only in pass 0: pass 1 stack full, pass 2 global enable off
    for (int i = 0; i < 3; i++) begin
      a = 8'($urandom) & 8'h3f;
      d = 8'($urandom);
      stack_full_i <= (i == 1);
      gie_i <= (i != 2);
      i_core.store(a, d);
      exp_rd(NVMC_IND_OFS, 8'h0c);
      i_core.store_end();
      exp_rd(NVMC_INTC_OFS, 8'h0f);
      #1;
      check({7'h00, irq_req_o}, {7'h00, i == 0});
      @(posedge mclk_i);
      irq_ack_i <= 1'b1;
      @(posedge mclk_i);
      irq_ack_i <= 1'b0;
      exp_rd(NVMC_INTC_OFS, (i == 0) ? 8'h07 : 8'h0f);
      i_core.wr(NVMC_INTC_OFS, 8'h03);
    end
    i_core.wr(NVMC_DATA_OFS, ~d);
    i_core.wr(NVMC_IND_OFS, 8'h04);
    exp_rd(NVMC_IND_OFS, 8'h00);
    i_core.fetch(a);
    exp_rd(NVMC_DATA_OFS, d);
    i_core.wr(NVMC_ADDR_OFS, a ^ 8'h01);
    exp_rd(NVMC_DATA_OFS, d);
    i_core.wr(NVMC_IND_OFS, 8'h00);
    i_core.wr(NVMC_IND_OFS, 8'h01);
    exp_rd(NVMC_IND_OFS, 8'h00);
    i_core.idle();
    repeat (2) @(posedge mclk_i);
    finish_test();
  end
endmodule : tb_data_eeprom_access_ctrl
`default_nettype wire
